//--- hdl/srl_top.sv
// set-reset latch with software, pin, divider and comparator sources
// assumes comparator outputs already synchronised upstream, pins asynchronous
module srl_top (
  input  wire logic       clock_i,
  input  wire logic       nrst_i,
  input  wire logic [3:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  input  wire logic       latch_ext_input_pin_i,
  input  wire logic       cmp1_synced_output_i,
  input  wire logic       cmp2_synced_output_i,
  output logic            true_out_pin_o,
  output logic            true_out_pin_oe_o,
  output logic            compl_out_pin_o,
  output logic            compl_out_pin_oe_o
);
  import srl_pkg::*;

  // ************************************************************
  // reset release
  // ************************************************************
  logic rst_s1_q;
  logic rst_n_q;
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // ************************************************************
  // input synchronisers
  // ************************************************************
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  always_ff @(posedge clock_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
    end else begin
      sync1_q <= {cmp2_synced_output_i, cmp1_synced_output_i, latch_ext_input_pin_i};
      sync2_q <= sync1_q;
    end
  end
  logic pin_s;
  logic cmp1_s;
  logic cmp2_s;
  assign pin_s  = sync2_q[0];
  assign cmp1_s = sync2_q[1];
  assign cmp2_s = sync2_q[2];

  // ************************************************************
  // registers
  // ************************************************************
  logic [7:0] ctrl_q;
  logic [7:0] srcen_q;
  logic       soft_set_q;
  logic       soft_rst_q;
  logic       wr_ctrl;
  logic       wr_srcen;
  assign wr_ctrl  = wr_i && (addr_i == SRL_ADDR_CTRL);
  assign wr_srcen = wr_i && (addr_i == SRL_ADDR_SRCEN);

  // pulse bits are not stored, so they read back zero
  always_ff @(posedge clock_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ctrl_q <= SRL_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_q <= {wdata_i[7:2], 2'b00}; // RULE_10
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      srcen_q <= SRL_SRCEN_RESET;
    end else if (wr_srcen) begin
      srcen_q <= wdata_i;
    end
  end

  // one-cycle pulses from write-one; writing zero leaves them idle
  always_ff @(posedge clock_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      soft_set_q <= 1'b0;
      soft_rst_q <= 1'b0;
    end else begin
      soft_set_q <= wr_ctrl && wdata_i[SRL_CTRL_PS_BIT]; // RULE_08
      soft_rst_q <= wr_ctrl && wdata_i[SRL_CTRL_PR_BIT]; // RULE_09
    end
  end

  // ************************************************************
  // periodic pulse divider
  // ************************************************************
  logic [SRL_DIV_W-1:0] div_q;
  logic [2:0]           div_code;
  logic [SRL_DIV_W-1:0] div_mask;
  logic                 div_pulse;
  assign div_code = ctrl_q[SRL_CTRL_DIV_LSB +: 3];
  // mask of the low code+2 bits; pulse when they are all zero
  assign div_mask = SRL_DIV_W'((11'h004 << div_code) - 11'h001);
  assign div_pulse = ((div_q & div_mask) == SRL_DIV_RESET); // RULE_07

  always_ff @(posedge clock_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      div_q <= SRL_DIV_RESET;
    end else begin
      div_q <= div_q + SRL_DIV_W'(1);
    end
  end

  // ************************************************************
  // source gathering
  // ************************************************************
  logic set_in;
  logic rst_in;
  assign set_in = soft_set_q
                | (srcen_q[SRL_EN_SPIN_BIT] & pin_s)      // RULE_11
                | (srcen_q[SRL_EN_SDIV_BIT] & div_pulse)  // RULE_12
                | (srcen_q[SRL_EN_SC2_BIT]  & cmp2_s)     // RULE_13
                | (srcen_q[SRL_EN_SC1_BIT]  & cmp1_s);    // RULE_14 RULE_21
  assign rst_in = soft_rst_q
                | (srcen_q[SRL_EN_RPIN_BIT] & pin_s)      // RULE_15
                | (srcen_q[SRL_EN_RDIV_BIT] & div_pulse)  // RULE_16
                | (srcen_q[SRL_EN_RC2_BIT]  & cmp2_s)     // RULE_17
                | (srcen_q[SRL_EN_RC1_BIT]  & cmp1_s);    // RULE_18 RULE_21

  // ************************************************************
  // latch core
  // ************************************************************
  // modelled as a clocked hold: state keeps without source activity;
  // the device reset does not touch it, software initialises it
  logic latch_q;
  always_ff @(posedge clock_i) begin
    if (rst_in) begin
      latch_q <= 1'b0;                                     // RULE_19
    end else if (set_in) begin
      latch_q <= 1'b1;                                     // RULE_20
    end
  end

  // ************************************************************
  // output pins
  // ************************************************************
  logic len;
  assign len = ctrl_q[SRL_CTRL_LEN_BIT];
  // enables gate each pin separately, so both may drive at once
  assign true_out_pin_oe_o  = len & ctrl_q[SRL_CTRL_QEN_BIT];  // RULE_01 RULE_04 RULE_03
  assign compl_out_pin_oe_o = len & ctrl_q[SRL_CTRL_NQEN_BIT]; // RULE_02 RULE_04 RULE_03
  // output data forced low while undriven so no unknown leaks out
  assign true_out_pin_o  = true_out_pin_oe_o & latch_q;
  assign compl_out_pin_o = compl_out_pin_oe_o & ~latch_q;

  // ************************************************************
  // read port
  // ************************************************************
  always_ff @(posedge clock_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      if (addr_i == SRL_ADDR_CTRL) begin
        rdata_o <= ctrl_q;
      end else if (addr_i == SRL_ADDR_SRCEN) begin
        rdata_o <= srcen_q;
      end else if (addr_i == SRL_ADDR_STATUS) begin
        rdata_o <= {7'h00, latch_q === 1'b1};
      end else begin
        rdata_o <= 8'h00;
      end
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_q);

  true_pin_gate_a : assert property (true_out_pin_oe_o |-> len && ctrl_q[3]) // RULE_01
    else $error("true pin driven without enables");
  compl_pin_gate_a : assert property (compl_out_pin_oe_o |-> len && ctrl_q[2]) // RULE_02
    else $error("complement pin driven without enables");
  disabled_quiet_a : assert property (!len |-> !true_out_pin_oe_o && !compl_out_pin_oe_o) // RULE_04
    else $error("pin driven while latch disabled");
  // a reset source active in the pulse cycle legitimately overrides the soft set
  soft_set_pulse_a : assert property (wr_ctrl && wdata_i[1] |=> soft_set_q ##1 (latch_q || $past(rst_in))) // RULE_08
    else $error("soft set did not set latch");
  soft_rst_pulse_a : assert property (wr_ctrl && wdata_i[0] |=> soft_rst_q ##1 !latch_q) // RULE_09
    else $error("soft reset did not clear latch");
  pulse_bits_zero_a : assert property (ctrl_q[1:0] == 2'b00) // RULE_10
    else $error("pulse bits stored");
  reset_wins_a : assert property (rst_in |=> !latch_q) // RULE_19
    else $error("reset did not dominate");
  // a code change inside the window changes the mask on the free-running counter, so it excuses the check
  div_code0_a : assert property (div_code == 3'd0 && div_pulse |=> (!div_pulse || div_code != 3'd0) [*3] ##1 (div_pulse || div_code != 3'd0)) // RULE_07
    else $error("divider period wrong");
  set_source_a : assert property (set_in && !rst_in |=> latch_q) // RULE_21
    else $error("set source ignored");
  both_pins_a : assert property (len && ctrl_q[3] && ctrl_q[2] |-> true_out_pin_oe_o && compl_out_pin_oe_o) // RULE_03
    else $error("pins not driven together");
  pin_set_a : assert property (srcen_q[7] && pin_s && !rst_in |=> latch_q) // RULE_11
    else $error("pin set ignored");
  div_set_a : assert property (srcen_q[6] && div_pulse && !rst_in |=> latch_q) // RULE_12
    else $error("divider set ignored");
  cmp2_set_a : assert property (srcen_q[5] && cmp2_s && !rst_in |=> latch_q) // RULE_13
    else $error("comparator 2 set ignored");
  cmp1_set_a : assert property (srcen_q[4] && cmp1_s && !rst_in |=> latch_q) // RULE_14
    else $error("comparator 1 set ignored");
  pin_rst_a : assert property (srcen_q[3] && pin_s |=> !latch_q) // RULE_15
    else $error("pin reset ignored");
  div_rst_a : assert property (srcen_q[2] && div_pulse |=> !latch_q) // RULE_16
    else $error("divider reset ignored");
  cmp2_rst_a : assert property (srcen_q[1] && cmp2_s |=> !latch_q) // RULE_17
    else $error("comparator 2 reset ignored");
  cmp1_rst_a : assert property (srcen_q[0] && cmp1_s |=> !latch_q) // RULE_18
    else $error("comparator 1 reset ignored");

  both_pins_c  : cover property (true_out_pin_oe_o && compl_out_pin_oe_o);
  div_set_c    : cover property (srcen_q[6] && div_pulse && !rst_in);
  set_clash_c  : cover property (set_in && rst_in);
  div_rst_c    : cover property (srcen_q[2] && div_pulse && set_in);
endmodule : srl_top

//--- include/srl_pkg.sv
// constants shared by the pulse-source latch design
// assumes a single 50 MHz system clock and a plain register port
//
// Behaviour
// RULE_01 - true output drives its pin only when latch and true-pin enables are set
// RULE_02 - inverted output drives its pin only when latch and complement-pin enables set
// RULE_03 - both outputs may drive their pins at the same time
// RULE_04 - latch enable bit 7 clear disables latch; pin enables then have no effect
// RULE_05 - software clears port direction bits so pin drivers turn on
// RULE_06 - latch state undefined after reset; software forces it before enabling pins
// RULE_07 - divider code n gives one-cycle pulse every 2^(n+2) cycles
// RULE_08 - writing one to soft set bit pulses set input one cycle; zero does nothing
// RULE_09 - writing one to soft reset bit pulses reset one cycle; zero does nothing
// RULE_10 - soft set and reset bits are write-one only, self clear, read zero
// RULE_11 - pin set enable lets high input pin set the latch
// RULE_12 - divider set enable lets each divider pulse set the latch
// RULE_13 - comparator-2 set enable lets its high output set the latch
// RULE_14 - comparator-1 set enable lets its high output set the latch
// RULE_15 - pin reset enable lets high input pin reset the latch
// RULE_16 - divider reset enable lets each divider pulse reset the latch
// RULE_17 - comparator-2 reset enable lets its high output reset the latch
// RULE_18 - comparator-1 reset enable lets its high output reset the latch
// RULE_19 - set and reset together: reset wins, true output zero, complement one
// RULE_20 - latch holds state itself; active-high set and reset from all sources
// RULE_21 - effective set and reset are the OR of all enabled sources
package srl_pkg;
  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [3:0] SRL_ADDR_CTRL    = 4'h0;
  localparam logic [3:0] SRL_ADDR_SRCEN   = 4'h1;
  localparam logic [3:0] SRL_ADDR_STATUS  = 4'h2;
  localparam logic [7:0] SRL_CTRL_RESET   = 8'h00;
  localparam logic [7:0] SRL_SRCEN_RESET  = 8'h00;
  // ************************************************************
  // field positions, control register
  // ************************************************************
  localparam int SRL_CTRL_LEN_BIT  = 7;
  localparam int SRL_CTRL_DIV_LSB  = 4;
  localparam int SRL_CTRL_QEN_BIT  = 3;
  localparam int SRL_CTRL_NQEN_BIT = 2;
  localparam int SRL_CTRL_PS_BIT   = 1;
  localparam int SRL_CTRL_PR_BIT   = 0;
  // ************************************************************
  // field positions, source enable register
  // ************************************************************
  localparam int SRL_EN_SPIN_BIT  = 7;
  localparam int SRL_EN_SDIV_BIT  = 6;
  localparam int SRL_EN_SC2_BIT   = 5;
  localparam int SRL_EN_SC1_BIT   = 4;
  localparam int SRL_EN_RPIN_BIT  = 3;
  localparam int SRL_EN_RDIV_BIT  = 2;
  localparam int SRL_EN_RC2_BIT   = 1;
  localparam int SRL_EN_RC1_BIT   = 0;
  // ************************************************************
  // divider
  // ************************************************************
  localparam int          SRL_DIV_W     = 9;
  localparam logic [8:0]  SRL_DIV_RESET = 9'h000;
endpackage : srl_pkg

//--- verification/srl_partner.sv
// far-side model: comparator outputs, external input pin and the two output pin wires
// assumes the bench requests source levels; pin wires resolved from the driver enables
module srl_partner (
  input  wire logic       clock_i,
  input  wire logic [2:0] src_req_i,
  input  wire logic       true_q_i,
  input  wire logic       true_oe_i,
  input  wire logic       compl_q_i,
  input  wire logic       compl_oe_i,
  output logic            ext_pin_o,
  output logic            cmp1_o,
  output logic            cmp2_o,
  output logic            true_lvl_o,
  output logic            compl_lvl_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic true_last_q  = 1'b0;
  logic compl_last_q = 1'b0;
  assign ext_pin_o = src_req_i[0];
  assign cmp1_o    = src_req_i[1];
  assign cmp2_o    = src_req_i[2];
  always @(posedge clock_i) begin
    if (true_oe_i) true_last_q <= true_q_i;
    if (compl_oe_i) compl_last_q <= compl_q_i;
  end
  // pin drives only while its driver enable is high; a floating wire shows the inverse of its last driven level
  assign true_lvl_o  = true_oe_i ? true_q_i : ~true_last_q;
  assign compl_lvl_o = compl_oe_i ? compl_q_i : ~compl_last_q;
endmodule // srl_partner

//--- verification/test_sr_latch_with_pulse_sources.sv
// self-checking bench for the pulse-source latch
// assumes srl_top with the plain register port and the far-side model srl_partner
module test_sr_latch_with_pulse_sources;
  import srl_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i = 1'b0, nrst_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00, rdata_o;
  logic [2:0] src_req = 3'b000;
  logic ext, c1, c2, tq, toe, cq, coe, tlvl, clvl, s;
  logic [7:0] v;
  int err_total = 0, cmp_count = 0, cyc = 0;
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
  srl_top DUT (.clock_i(clock_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .latch_ext_input_pin_i(ext),
    .cmp1_synced_output_i(c1), .cmp2_synced_output_i(c2), .true_out_pin_o(tq),
    .true_out_pin_oe_o(toe), .compl_out_pin_o(cq), .compl_out_pin_oe_o(coe));
  srl_partner far (.clock_i(clock_i), .src_req_i(src_req), .true_q_i(tq), .true_oe_i(toe),
    .compl_q_i(cq), .compl_oe_i(coe), .ext_pin_o(ext), .cmp1_o(c1), .cmp2_o(c2),
    .true_lvl_o(tlvl), .compl_lvl_o(clvl));
  initial forever #10 clock_i = ~clock_i;
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // a hang is cut short well beyond the longest divider sweep
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr_i <= a; wdata_i <= d; wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock_i);
    addr_i <= a; rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic st(output logic q);
    logic [7:0] r;
    wt(3);
    rd(SRL_ADDR_STATUS, r);
    q = r[0];
  endtask
  task automatic t_regs();
    rd(SRL_ADDR_CTRL, v); `CHK("ctrl reset", SRL_CTRL_RESET, v)
    rd(SRL_ADDR_SRCEN, v); `CHK("srcen reset", SRL_SRCEN_RESET, v)
    wr(SRL_ADDR_SRCEN, 8'h5A); rd(SRL_ADDR_SRCEN, v); `CHK("srcen rw", 8'h5A, v)
    wr(SRL_ADDR_SRCEN, 8'h00); wr(4'h3, 8'hFF); rd(4'h3, v); `CHK("unmapped", 8'h00, v)
    wr(SRL_ADDR_CTRL, 8'h73); rd(SRL_ADDR_CTRL, v); `CHK("ctrl rw", 8'h70, v)
    st(s); `CHK("both pulses", 1'b0, s)
    wr(SRL_ADDR_CTRL, 8'h02); st(s); `CHK("soft set", 1'b1, s)
    wr(SRL_ADDR_CTRL, 8'h00); st(s); `CHK("set hold", 1'b1, s)
    wr(SRL_ADDR_CTRL, 8'h01); st(s); `CHK("soft reset", 1'b0, s)
  endtask
  task automatic t_pins();
    wr(SRL_ADDR_CTRL, 8'h01); // latch known before pins are enabled
    wr(SRL_ADDR_CTRL, 8'h0C); wt(2); `CHK("off oe", 2'b00, {toe, coe})
    wr(SRL_ADDR_CTRL, 8'h8C); wt(2); `CHK("pins q0", 4'b1101, {toe, coe, tq, cq})
    wr(SRL_ADDR_CTRL, 8'h8E); wt(3); `CHK("pins q1", 4'b1110, {toe, coe, tq, cq})
    `CHK("wires", 2'b10, {tlvl, clvl})
    wr(SRL_ADDR_CTRL, 8'h88); wt(2); `CHK("true only", 3'b101, {toe, coe, tq})
  endtask
  task automatic t_src();
    logic [7:0] en_t [8] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01};
    logic [2:0] rq_t [8] = '{3'd1, 3'd0, 3'd4, 3'd2, 3'd1, 3'd0, 3'd4, 3'd2};
    for (int i = 0; i < 8; i++) begin
      wr(SRL_ADDR_SRCEN, 8'h00);
      wr(SRL_ADDR_CTRL, (i < 4) ? 8'h01 : 8'h02);
      src_req <= rq_t[i];
      wt(12); st(s); `CHK("src off", (i < 4) ? 1'b0 : 1'b1, s)
      wr(SRL_ADDR_SRCEN, en_t[i]);
      wt(12); st(s); `CHK("src on", (i < 4) ? 1'b1 : 1'b0, s)
      src_req <= 3'd0;
    end
  endtask
  // pin holds set while each divider pulse resets: one low cycle per period
  task automatic t_div();
    int n, c;
    wr(SRL_ADDR_SRCEN, 8'h84);
    src_req <= 3'd1;
    for (int k = 0; k < 8; k++) begin
      wr(SRL_ADDR_CTRL, {1'b1, k[2:0], 4'b1000}); wt(6);
      c = 0; while (tq !== 1'b0 && c < 1100) begin wt(1); c++; end
      n = 0; wt(1); while (tq !== 1'b0 && n < 1100) begin wt(1); n++; end
      `CHK("div period", 1 << (k + 2), n + 1)
    end
  endtask
  initial begin
    repeat (20) @(posedge clock_i);
    nrst_i <= 1'b1;
    wt(4);
    t_regs();
    t_pins();
    t_src();
    t_div();
    close_out();
  end
endmodule // test_sr_latch_with_pulse_sources
